//--- src/nva_top.v
// Operation
// - writing the command with run set and direction one makes the engine perform a one-byte read.
// - command bit 7 stays set for the whole transfer and hardware clears it at the end.
// - a finished read leaves the fetched byte in the data register.
// - a read-only result register reports whether the last transfer succeeded.
// - result bit 0 is set when the memory did not acknowledge, meaning it is still busy writing.
// - the vendor IN request 0x03 of length four returns the four identity bytes, value and index ignored.
// - the vendor OUT request 0x04 sets the processor-halt bit, other fields ignored.
// - the vendor OUT request 0x81 of length zero writes the index low byte at the address in the value field.
// - the vendor IN request 0x82 of length one returns the byte at the address in the value field.
// - the ATA pins are released to high impedance while the power-on reset is asserted.
// - the test-select input reads zero by default; zero is normal and one is test mode.
// - the serial pins have pull-ups and may serve as general port bits when the link is unused.
// - command bit 7 is run and bit 0 is direction, zero write and one read.
`timescale 1ns/1ps
`default_nettype none
`include "nva_defines.vh"

module nva_top #(
  parameter [31:0] CHIP_ID = 32'h0102_0304, // arbitrary value
  parameter        QUARTER = `NVA_SCL_QUARTER_CYC
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        cpu_wr,
  input  wire        cpu_rd,
  input  wire [15:0] cpu_addr,
  input  wire [7:0]  cpu_wdata,
  output reg  [7:0]  cpu_rdata_q,
  output reg         cpu_halt_q,
  input  wire        setup_valid,
  input  wire [7:0]  setup_type,
  input  wire [7:0]  setup_request,
  input  wire [15:0] setup_value,
  input  wire [15:0] setup_index,
  input  wire [15:0] setup_length,
  output reg         setup_done_q,
  output reg         setup_stall_q,
  output reg         in_valid_q,
  output reg  [7:0]  in_data_q,
  input  wire        in_ready,
  output reg  [15:0] ds_addr_q,
  output reg  [7:0]  ds_wdata_q,
  output reg         ds_wr_q,
  output reg         ds_rd_q,
  input  wire [7:0]  ds_rdata,
  input  wire        scl_in,
  output reg         scl_out_q,
  output reg         scl_oe_q,
  input  wire        sda_in,
  output reg         sda_out_q,
  output reg         sda_oe_q,
  output reg         pullup_en_q,
  input  wire        link_unused,
  input  wire        alt_port_bit_a_out,
  input  wire        alt_port_bit_a_oe,
  input  wire        alt_port_bit_b_out,
  input  wire        alt_port_bit_b_oe,
  output reg         alt_port_bit_a_q,
  output reg         alt_port_bit_b_q,
  input  wire        power_on_reset_n,
  input  wire        test_select,
  output reg         ata_hiz_q,
  output reg         test_mode_q
);

  localparam [3:0] E_IDLE   = 4'h0;
  localparam [3:0] E_START  = 4'h1;
  localparam [3:0] E_CODEW  = 4'h2;
  localparam [3:0] E_WORD   = 4'h3;
  localparam [3:0] E_DATA   = 4'h4;
  localparam [3:0] E_RSTART = 4'h5;
  localparam [3:0] E_CODER  = 4'h6;
  localparam [3:0] E_READ   = 4'h7;
  localparam [3:0] E_STOP   = 4'h8;

  localparam [1:0] U_IDLE = 2'h0;
  localparam [1:0] U_WAIT = 2'h1;
  localparam [1:0] U_SEND = 2'h2;

  reg  [3:0]  sync1_q;
  reg  [3:0]  sync2_q;
  reg  [7:0]  word_q;
  reg  [7:0]  byte_q;
  reg  [7:0]  code_q;
  reg         run_q;
  reg         dir_q;
  reg         fail_q;
  reg  [3:0]  eng_q;
  reg         go_q;
  reg  [1:0]  usb_q;
  reg  [31:0] send_q;
  reg  [2:0]  send_cnt_q;
  reg  [1:0]  op_d;
  reg  [7:0]  tx_d;
  reg  [3:0]  next_d;
  reg  [7:0]  acc_rdata;
  wire        done;
  wire [7:0]  rx;
  wire        nack;
  wire        scl_low;
  wire        sda_low;
  wire        is_chip_id;
  wire        is_hold;
  wire        is_ds_wr;
  wire        is_ds_rd;
  wire        take;
  wire        usb_own_wr;
  wire        cpu_ok;
  wire        acc_wr;
  wire [15:0] acc_addr;
  wire [15:0] rd_addr;
  wire [7:0]  acc_wdata;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: scl, sda, power-on reset, test select
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 4'h7;
      sync2_q <= 4'h7;
    end else begin
      sync1_q <= {test_select, power_on_reset_n, sda_in, scl_in};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vendor request decode; each one checks only the fields it cares about
  assign is_chip_id = (setup_type == `NVA_TYPE_IN) &&
                      (setup_request == `NVA_REQ_CHIP_ID) &&
                      (setup_length == `NVA_LEN_CHIP_ID);
  assign is_hold    = (setup_type == `NVA_TYPE_OUT) &&
                      (setup_request == `NVA_REQ_HOLD);
  assign is_ds_wr   = (setup_type == `NVA_TYPE_OUT) &&
                      (setup_request == `NVA_REQ_DS_WRITE) &&
                      (setup_length == `NVA_LEN_NONE);
  assign is_ds_rd   = (setup_type == `NVA_TYPE_IN) &&
                      (setup_request == `NVA_REQ_DS_READ) &&
                      (setup_length == `NVA_LEN_DS_READ);
  assign take       = setup_valid && (usb_q == U_IDLE);

  function own_hit;
    input [15:0] a;
    begin
      own_hit = (a >= `NVA_ADDR_WORD) && (a <= `NVA_ADDR_RESULT);
    end
  endfunction

  // host traffic wins; a halted processor is shut out of the registers
  assign usb_own_wr = take && is_ds_wr && own_hit(setup_value);
  assign cpu_ok     = !cpu_halt_q;
  assign acc_wr     = usb_own_wr || (cpu_ok && cpu_wr);
  assign acc_addr   = usb_own_wr ? setup_value : cpu_addr;
  assign acc_wdata  = usb_own_wr ? setup_index[7:0] : cpu_wdata;
  assign rd_addr    = (take && is_ds_rd) ? setup_value : cpu_addr;

  always @* begin
    case (rd_addr)
      `NVA_ADDR_WORD:   acc_rdata = word_q;
      `NVA_ADDR_BYTE:   acc_rdata = byte_q;
      `NVA_ADDR_CODE:   acc_rdata = code_q;
      `NVA_ADDR_CMD:    acc_rdata = {run_q, 6'h00, dir_q};
      `NVA_ADDR_RESULT: acc_rdata = {7'h00, fail_q};
      default:          acc_rdata = `NVA_RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // engine sequencing
  always @* begin
    op_d   = `NVA_OP_WRITE;
    tx_d   = {code_q[7:1], 1'b0};
    next_d = E_STOP;
    case (eng_q)
      E_START: begin
        op_d   = `NVA_OP_START;
        next_d = E_CODEW;
      end
      E_CODEW: next_d = nack ? E_STOP : E_WORD;
      E_WORD: begin
        tx_d   = word_q;
        next_d = nack ? E_STOP : (dir_q ? E_RSTART : E_DATA);
      end
      E_DATA: tx_d = byte_q;
      E_RSTART: begin
        op_d   = `NVA_OP_START;
        next_d = E_CODER;
      end
      E_CODER: begin
        tx_d   = {code_q[7:1], 1'b1};
        next_d = nack ? E_STOP : E_READ;
      end
      E_READ: op_d = `NVA_OP_READ;
      E_STOP: begin
        op_d   = `NVA_OP_STOP;
        next_d = E_IDLE;
      end
      default: next_d = E_IDLE;
    endcase
  end

  nva_i2c_byte #(
    .QUARTER (QUARTER)
  ) u_byte (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .go          (go_q),
    .op          (op_d),
    .tx_byte     (tx_d),
    .master_nack (1'b1),
    .sda_in      (sync2_q[1]),
    .done_q      (done),
    .rx_q        (rx),
    .nack_q      (nack),
    .scl_low_q   (scl_low),
    .sda_low_q   (sda_low)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers and engine state
  always @(posedge clk) begin
    if (sys_rst) begin
      word_q <= `NVA_RST_BYTE;
      byte_q <= `NVA_RST_BYTE;
      code_q <= `NVA_RST_BYTE;
      run_q  <= 1'b0;
      dir_q  <= 1'b0;
      fail_q <= 1'b0;
      eng_q  <= E_IDLE;
      go_q   <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (acc_wr) begin
        case (acc_addr)
          `NVA_ADDR_WORD: word_q <= acc_wdata;
          `NVA_ADDR_BYTE: byte_q <= acc_wdata;
          `NVA_ADDR_CODE: code_q <= acc_wdata;
          `NVA_ADDR_CMD: begin
            // a command written mid-transfer is dropped
            if (!run_q) begin
              dir_q <= acc_wdata[`NVA_CMD_DIR_BIT];
              if (acc_wdata[`NVA_CMD_RUN_BIT]) begin
                run_q  <= 1'b1;
                fail_q <= 1'b0;
                eng_q  <= E_START;
                go_q   <= 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
      if (done && eng_q != E_IDLE) begin
        eng_q <= next_d;
        go_q  <= (next_d != E_IDLE);
        if (nack && (eng_q == E_CODEW || eng_q == E_WORD ||
                     eng_q == E_DATA || eng_q == E_CODER))
          fail_q <= 1'b1;
        if (eng_q == E_READ)
          byte_q <= rx;
        if (eng_q == E_STOP)
          run_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // processor side and vendor requests
  always @(posedge clk) begin
    if (sys_rst) begin
      cpu_rdata_q   <= `NVA_RST_BYTE;
      cpu_halt_q    <= 1'b0;
      setup_done_q  <= 1'b0;
      setup_stall_q <= 1'b0;
      in_valid_q    <= 1'b0;
      in_data_q     <= `NVA_RST_BYTE;
      ds_addr_q     <= 16'h0000;
      ds_wdata_q    <= `NVA_RST_BYTE;
      ds_wr_q       <= 1'b0;
      ds_rd_q       <= 1'b0;
      usb_q         <= U_IDLE;
      send_q        <= 32'h0000_0000;
      send_cnt_q    <= 3'h0;
    end else begin
      setup_done_q  <= 1'b0;
      setup_stall_q <= 1'b0;
      ds_wr_q       <= 1'b0;
      ds_rd_q       <= 1'b0;
      if (cpu_ok && cpu_rd && !(take && is_ds_rd))
        cpu_rdata_q <= acc_rdata;
      case (usb_q)
        U_IDLE: begin
          if (setup_valid) begin
            if (is_chip_id) begin
              in_valid_q <= 1'b1;
              in_data_q  <= CHIP_ID[31:24];
              send_q     <= {CHIP_ID[23:0], 8'h00};
              send_cnt_q <= `NVA_ID_BYTES;
              usb_q      <= U_SEND;
            end else if (is_hold) begin
              cpu_halt_q   <= 1'b1;
              setup_done_q <= 1'b1;
            end else if (is_ds_wr) begin
              setup_done_q <= 1'b1;
              if (!own_hit(setup_value)) begin
                ds_addr_q  <= setup_value;
                ds_wdata_q <= setup_index[7:0];
                ds_wr_q    <= 1'b1;
              end
            end else if (is_ds_rd) begin
              if (own_hit(setup_value)) begin
                in_valid_q <= 1'b1;
                in_data_q  <= acc_rdata;
                send_cnt_q <= 3'h1;
                usb_q      <= U_SEND;
              end else begin
                ds_addr_q <= setup_value;
                ds_rd_q   <= 1'b1;
                usb_q     <= U_WAIT;
              end
            end else begin
              setup_stall_q <= 1'b1;
            end
          end
        end
        U_WAIT: begin
          // outer data space answers in the strobe cycle itself, sampled at its end
          in_valid_q <= 1'b1;
          in_data_q  <= ds_rdata;
          send_cnt_q <= 3'h1;
          usb_q      <= U_SEND;
        end
        U_SEND: begin
          if (setup_valid)
            setup_stall_q <= 1'b1;
          if (in_ready) begin
            send_cnt_q <= send_cnt_q - 3'h1;
            in_data_q  <= send_q[31:24];
            send_q     <= {send_q[23:0], 8'h00};
            if (send_cnt_q == 3'h1) begin
              in_valid_q <= 1'b0;
              usb_q      <= U_IDLE;
            end
          end
        end
        default: usb_q <= U_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: open drain while the link is in use, port bits otherwise
  always @(posedge clk) begin
    if (sys_rst) begin
      scl_out_q        <= 1'b0;
      scl_oe_q         <= 1'b0;
      sda_out_q        <= 1'b0;
      sda_oe_q         <= 1'b0;
      pullup_en_q      <= 1'b1;
      alt_port_bit_a_q <= 1'b1;
      alt_port_bit_b_q <= 1'b1;
      ata_hiz_q        <= 1'b1;
      test_mode_q      <= 1'b0;
    end else begin
      pullup_en_q      <= 1'b1;
      scl_out_q        <= link_unused ? alt_port_bit_a_out : 1'b0;
      scl_oe_q         <= link_unused ? alt_port_bit_a_oe : scl_low;
      sda_out_q        <= link_unused ? alt_port_bit_b_out : 1'b0;
      sda_oe_q         <= link_unused ? alt_port_bit_b_oe : sda_low;
      alt_port_bit_a_q <= sync2_q[0];
      alt_port_bit_b_q <= sync2_q[1];
      // three-flop lag on the pin; high impedance while reset is asserted, driven again only after it is gone
      ata_hiz_q        <= ~sync2_q[2];
      test_mode_q      <= sync2_q[3];
    end
  end

endmodule

`default_nettype wire

//--- src/nva_defines.vh
`ifndef NVA_DEFINES_VH
`define NVA_DEFINES_VH

// register map in the data space
`define NVA_ADDR_WORD       16'h40E0
`define NVA_ADDR_BYTE       16'h40E1
`define NVA_ADDR_CODE       16'h40E2
`define NVA_ADDR_CMD        16'h40E3
`define NVA_ADDR_RESULT     16'h40E4

// field positions and reset values
`define NVA_CMD_RUN_BIT     7
`define NVA_CMD_DIR_BIT     0
`define NVA_RESULT_FAIL_BIT 0
`define NVA_CODE_DIR_BIT    0
`define NVA_RST_BYTE        8'h00

// vendor control requests
`define NVA_TYPE_OUT        8'h40
`define NVA_TYPE_IN         8'hC0
`define NVA_REQ_CHIP_ID     8'h03
`define NVA_REQ_HOLD        8'h04
`define NVA_REQ_DS_WRITE    8'h81
`define NVA_REQ_DS_READ     8'h82
`define NVA_LEN_CHIP_ID     16'h0004
`define NVA_LEN_DS_READ     16'h0001
`define NVA_LEN_NONE        16'h0000
`define NVA_ID_BYTES        3'h4

// two-wire byte engine operations
`define NVA_OP_START        2'h0
`define NVA_OP_STOP         2'h1
`define NVA_OP_WRITE        2'h2
`define NVA_OP_READ         2'h3

// timing: one quarter of a serial clock period, least time
`define NVA_CLK_PERIOD_NS   10
`define NVA_SCL_QUARTER_NS  2500
`define NVA_SCL_QUARTER_CYC ((`NVA_SCL_QUARTER_NS + `NVA_CLK_PERIOD_NS - 1) / `NVA_CLK_PERIOD_NS)

`endif

//--- src/nva_i2c_byte.v
`timescale 1ns/1ps
`default_nettype none
`include "nva_defines.vh"

module nva_i2c_byte #(
  parameter QUARTER = `NVA_SCL_QUARTER_CYC
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       go,
  input  wire [1:0] op,
  input  wire [7:0] tx_byte,
  input  wire       master_nack,
  input  wire       sda_in,
  output reg        done_q,
  output reg  [7:0] rx_q,
  output reg        nack_q,
  output reg        scl_low_q,
  output reg        sda_low_q
);

  reg        busy_q;
  reg [1:0]  op_q;
  reg [7:0]  tx_q;
  reg        mnack_q;
  reg [15:0] qcnt_q;
  reg [1:0]  phase_q;
  reg [3:0]  bit_q;
  reg        scl_lo_d;
  reg        sda_lo_d;
  reg        dbit;

  ////////////////////////////////////////////////////////////////////////
  // line levels per phase; scl high in phases 1 and 2, and also in phase 3 for a stop
  always @* begin
    dbit = (bit_q == 4'h8) ? ((op_q == `NVA_OP_WRITE) ? 1'b1 : mnack_q)
         : ((op_q == `NVA_OP_WRITE) ? tx_q[7] : 1'b1);
    case (op_q)
      `NVA_OP_START: begin
        scl_lo_d = (phase_q == 2'h0) || (phase_q == 2'h3);
        sda_lo_d = phase_q[1];
      end
      `NVA_OP_STOP: begin
        scl_lo_d = (phase_q == 2'h0);
        sda_lo_d = ~phase_q[1];
      end
      default: begin
        scl_lo_d = (phase_q == 2'h0) || (phase_q == 2'h3);
        sda_lo_d = ~dbit;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (sys_rst) begin
      busy_q    <= 1'b0;
      op_q      <= `NVA_OP_STOP;
      tx_q      <= `NVA_RST_BYTE;
      mnack_q   <= 1'b1;
      qcnt_q    <= 16'h0000;
      phase_q   <= 2'h0;
      bit_q     <= 4'h0;
      done_q    <= 1'b0;
      rx_q      <= `NVA_RST_BYTE;
      nack_q    <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (busy_q) begin
        scl_low_q <= scl_lo_d;
        sda_low_q <= sda_lo_d;
      end
      if (!busy_q) begin
        if (go) begin
          busy_q  <= 1'b1;
          op_q    <= op;
          tx_q    <= tx_byte;
          mnack_q <= master_nack;
          qcnt_q  <= 16'h0000;
          phase_q <= 2'h0;
          bit_q   <= 4'h0;
        end
      end else if (qcnt_q != QUARTER[15:0] - 16'h0001) begin
        qcnt_q <= qcnt_q + 16'h0001;
      end else begin
        qcnt_q  <= 16'h0000;
        phase_q <= phase_q + 2'h1;
        // sample in the middle of the high time
        if (op_q[1] && phase_q == 2'h1) begin
          if (bit_q == 4'h8)
            nack_q <= sda_in;
          else
            rx_q <= {rx_q[6:0], sda_in};
        end
        if (phase_q == 2'h3) begin
          if (!op_q[1] || bit_q == 4'h8) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            bit_q <= bit_q + 4'h1;
            tx_q  <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/nva_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module nva_checker #(
  parameter [31:0] CHIP_ID = 32'h0102_0304
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cpu_halt_q,
  input wire logic        setup_valid,
  input wire logic [7:0]  setup_type,
  input wire logic [7:0]  setup_request,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic        setup_done_q,
  input wire logic        setup_stall_q,
  input wire logic        in_valid_q,
  input wire logic [7:0]  in_data_q,
  input wire logic        in_ready,
  input wire logic [15:0] ds_addr_q,
  input wire logic [7:0]  ds_wdata_q,
  input wire logic        ds_wr_q,
  input wire logic        ds_rd_q,
  input wire logic [7:0]  ds_rdata,
  input wire logic        pullup_en_q,
  input wire logic        power_on_reset_n,
  input wire logic        ata_hiz_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // requests only count while the in handler is idle
  wire idle = !in_valid_q && !ds_rd_q;
  wire own  = setup_value >= 16'h40E0 && setup_value <= 16'h40E4;
  wire vout = setup_valid && idle && setup_type == 8'h40;
  wire vin  = setup_valid && idle && setup_type == 8'hC0;
  //////////////////////////////////////////////////////////////////////////
  sequence s_rd_strobe;
    ds_rd_q && ds_addr_q == $past(setup_value);
  endsequence
  sequence s_rd_byte;
    in_valid_q && in_data_q == $past(ds_rdata);
  endsequence
  property p_halt;
    vout && setup_request == 8'h04 |=> cpu_halt_q && setup_done_q;
  endproperty
  property p_halt_sticky;
    cpu_halt_q |=> cpu_halt_q;
  endproperty
  property p_chip_id;
    vin && setup_request == 8'h03 && setup_length == 16'h0004
      |=> in_valid_q && in_data_q == CHIP_ID[31:24];
  endproperty
  property p_in_hold;
    in_valid_q && !in_ready |=> in_valid_q && $stable(in_data_q);
  endproperty
  property p_ds_wr;
    vout && setup_request == 8'h81 && setup_length == 16'h0000 && !own
      |=> ds_wr_q && setup_done_q && ds_addr_q == $past(setup_value)
          && ds_wdata_q == $past(setup_index[7:0]);
  endproperty
  property p_ds_rd;
    vin && setup_request == 8'h82 && setup_length == 16'h0001 && !own
      |=> s_rd_strobe ##1 s_rd_byte;
  endproperty
  property p_stall;
    setup_valid && idle
      && !(setup_request inside {8'h03, 8'h04, 8'h81, 8'h82})
      |=> setup_stall_q;
  endproperty
  property p_hiz;
    !power_on_reset_n [*3] |=> ata_hiz_q;
  endproperty
  property p_pullup;
    1'b1 |-> pullup_en_q;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt request not taken");
  a_halt_sticky: assert property (p_halt_sticky)
    else $error("halt bit dropped");
  a_chip_id: assert property (p_chip_id)
    else $error("identity first byte wrong");
  a_in_hold: assert property (p_in_hold)
    else $error("in byte changed before taken");
  a_ds_wr: assert property (p_ds_wr)
    else $error("data space write wrong");
  a_ds_rd: assert property (p_ds_rd)
    else $error("data space read wrong");
  a_stall: assert property (p_stall)
    else $error("unknown request not stalled");
  a_hiz: assert property (p_hiz)
    else $error("ata pins not released");
  a_pullup: assert property (p_pullup)
    else $error("pull-ups off");
endmodule
bind nva_top nva_checker #(.CHIP_ID(CHIP_ID)) i_chk (
  .clk, .sys_rst, .cpu_halt_q, .setup_valid, .setup_type, .setup_request,
  .setup_value, .setup_index, .setup_length, .setup_done_q, .setup_stall_q,
  .in_valid_q, .in_data_q, .in_ready, .ds_addr_q, .ds_wdata_q, .ds_wr_q,
  .ds_rd_q, .ds_rdata, .pullup_en_q, .power_on_reset_n, .ata_hiz_q
);
`default_nettype wire

//--- testbench/nva_nvram_model.sv
`timescale 1ns/1ps
`default_nettype none
module nva_nvram_model #(
  parameter int BUSY_NS = 3000
) (
  input  wire logic scl,
  input  wire logic sda,
  output var logic  sda_low
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr;
  logic       act = 1'b0, rd_pend, rd_mode, wrote = 1'b0;
  int         bitn, byten;
  time        busy_end = 0;
  initial sda_low = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    bitn = 0;
    byten = 0;
    rd_mode = 1'b0;
    rd_pend = 1'b0;
  end
  // stop opens the internal write period
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    if (wrote) busy_end = $time + BUSY_NS;
    wrote = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8 && rd_mode && sda) rd_pend = 1'b0;
    bitn++;
  end
  // only ever drive while scl is low, so no false stop
  always @(negedge scl) if (act) begin
    if (bitn == 8 && rd_mode) sda_low = 1'b0;
    else if (bitn == 8) begin
      sda_low = byten != 0 || $time >= busy_end;
      if (byten == 0) rd_pend = sh[0] && sda_low;
      if (byten == 1) ptr = sh;
      if (byten == 2) begin
        mem[ptr] = sh;
        wrote = 1'b1;
      end
      byten++;
    end else if (bitn == 9) begin
      bitn = 0;
      rd_mode = rd_pend;
      sda_low = rd_mode && !mem[ptr][7];
    end else if (rd_mode) sda_low = !mem[ptr][7 - bitn];
  end
endmodule
`default_nettype wire

//--- testbench/nva_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nva_top_bench;
  localparam [31:0] ID = 32'h5A6B_7C8D; // arbitrary value
  logic        clk, sys_rst, cpu_wr, cpu_rd, setup_valid, in_ready, mem_low;
  logic        link_unused, power_on_reset_n, test_select;
  logic [15:0] cpu_addr, setup_value, setup_index, setup_length, ds_addr_q;
  logic [7:0]  cpu_wdata, setup_type, setup_request, ds_rdata, rd, cmd;
  logic [7:0]  cpu_rdata_q, in_data_q, ds_wdata_q;
  logic        cpu_halt_q, setup_done_q, setup_stall_q, in_valid_q;
  logic        ds_wr_q, ds_rd_q, scl_out_q, scl_oe_q, sda_out_q, sda_oe_q;
  logic        pullup_en_q, ata_hiz_q, test_mode_q;
  logic        pa_o, pa_e, pb_o, pb_e, pa_q, pb_q;
  wire         scl_in, sda_in;
  int          errors, n_tests, cyc, k;
  // open drain with pull-ups: high unless someone pulls low
  assign scl_in = !(scl_oe_q && !scl_out_q);
  assign sda_in = !(sda_oe_q && !sda_out_q) && !mem_low;
  nva_top #(.CHIP_ID(ID), .QUARTER(4)) i_dut (
    .clk, .sys_rst, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata_q,
    .cpu_halt_q, .setup_valid, .setup_type, .setup_request, .setup_value,
    .setup_index, .setup_length, .setup_done_q, .setup_stall_q, .in_valid_q,
    .in_data_q, .in_ready, .ds_addr_q, .ds_wdata_q, .ds_wr_q, .ds_rd_q,
    .ds_rdata, .scl_in, .scl_out_q, .scl_oe_q, .sda_in, .sda_out_q,
    .sda_oe_q, .pullup_en_q, .link_unused, .alt_port_bit_a_out(pa_o),
    .alt_port_bit_a_oe(pa_e), .alt_port_bit_b_out(pb_o),
    .alt_port_bit_b_oe(pb_e), .alt_port_bit_a_q(pa_q), .alt_port_bit_b_q(pb_q),
    .power_on_reset_n, .test_select, .ata_hiz_q, .test_mode_q
  );
  nva_nvram_model #(.BUSY_NS(3000)) i_mem (
    .scl(scl_in), .sda(sda_in), .sda_low(mem_low)
  );
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  // strobes drop for one edge so back-to-back calls never collide
  task automatic cwr(input logic [15:0] a, input logic [7:0] d);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    tick;
    cpu_wr = 1'b0;
    tick;
  endtask
  task automatic crd(input logic [15:0] a, output logic [7:0] d);
    cpu_rd = 1'b1;
    cpu_addr = a;
    tick;
    cpu_rd = 1'b0;
    tick;
    d = cpu_rdata_q;
  endtask
  task automatic setup(input logic [7:0] t, r, input logic [15:0] v, x, l);
    tick;
    setup_valid = 1'b1;
    setup_type = t;
    setup_request = r;
    setup_value = v;
    setup_index = x;
    setup_length = l;
    tick;
    setup_valid = 1'b0;
  endtask
  task automatic take(input logic [7:0] exp);
    for (int j = 0; j < 8 && in_valid_q !== 1'b1; j++) tick;
    chk("in_data", exp, in_data_q);
    in_ready = 1'b1;
    tick;
    in_ready = 1'b0;
    tick;
  endtask
  task automatic run_cmd(input logic [7:0] c, output logic [7:0] res);
    cwr(16'h40E3, c);
    crd(16'h40E3, cmd);
    chk("command busy", c, cmd);
    for (int j = 0; j < 2000 && cmd[7] !== 1'b0; j++) crd(16'h40E3, cmd);
    chk("command done", {1'b0, c[6:0]}, cmd);
    crd(16'h40E4, res);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole run is under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      $display("Error timeout expected finish seen hang");
      errors++;
      end_sim;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, cpu_wr, cpu_rd, setup_valid, in_ready, link_unused} = '0;
    {test_select, cpu_addr, cpu_wdata, setup_type, setup_request} = '0;
    {setup_value, setup_index, setup_length, ds_rdata} = '0;
    {pa_o, pa_e, pb_o, pb_e} = '0;
    sys_rst = 1'b1;
    power_on_reset_n = 1'b1;
    repeat (16) tick;
    sys_rst = 1'b0;
    for (k = 0; k < 5; k++) begin
      crd(16'h40E0 + k[15:0], rd);
      chk("reset value", 8'h00, rd);
    end
    cwr(16'h40E0, 8'h3C);
    cwr(16'h40E1, 8'hA5);
    cwr(16'h40E2, 8'hA0);
    cwr(16'h40E4, 8'hFF);
    crd(16'h40E4, rd);
    chk("result read only", 8'h00, rd);
    crd(16'h4100, rd);
    chk("unmapped", 8'h00, rd);
    $display("registers done");
    run_cmd(8'h80, rd);
    chk("write result", 8'h00, rd);
    cwr(16'h40E1, 8'h00);
    run_cmd(8'h81, rd);
    chk("poll busy", 8'h01, rd);
    for (k = 0; k < 20 && rd !== 8'h00; k++) run_cmd(8'h81, rd);
    crd(16'h40E1, rd);
    chk("read byte", 8'hA5, rd);
    $display("nvram done");
    setup(8'hC0, 8'h03, 16'h1234, 16'h5678, 16'h0004);
    setup(8'h40, 8'h04, 16'h0000, 16'h0000, 16'h0000);
    chk("busy stall", 2'b10, {setup_stall_q, cpu_halt_q});
    for (k = 3; k >= 0; k--) take(ID[k*8 +: 8]);
    setup(8'hC0, 8'h05, 16'h0000, 16'h0000, 16'h0001);
    chk("stall", 1'b1, setup_stall_q);
    setup(8'h40, 8'h04, 16'hFFFF, 16'hFFFF, 16'h0006);
    chk("halt", 2'b11, {setup_done_q, cpu_halt_q});
    cwr(16'h40E0, 8'h11);
    setup(8'hC0, 8'h82, 16'h40E0, 16'h0000, 16'h0001);
    take(8'h3C);
    setup(8'h40, 8'h81, 16'h40E2, 16'hFF5B, 16'h0000);
    chk("own write done", 1'b1, setup_done_q);
    setup(8'hC0, 8'h82, 16'h40E2, 16'h0000, 16'h0001);
    take(8'h5B);
    ds_rdata = 8'h3E;
    setup(8'h40, 8'h81, 16'h0123, 16'hAB77, 16'h0000);
    chk("outer write", {1'b1, 8'h77}, {ds_wr_q, ds_wdata_q});
    chk("outer addr", 16'h0123, ds_addr_q);
    setup(8'hC0, 8'h82, 16'h0123, 16'h0000, 16'h0001);
    chk("outer strobe", 1'b1, ds_rd_q);
    take(8'h3E);
    $display("vendor done");
    power_on_reset_n = 1'b0;
    repeat (4) tick;
    chk("ata released", 1'b1, ata_hiz_q);
    power_on_reset_n = 1'b1;
    repeat (4) tick;
    chk("ata driven", 1'b0, ata_hiz_q);
    chk("normal mode", 1'b0, test_mode_q);
    test_select = 1'b1;
    repeat (4) tick;
    chk("test mode", 1'b1, test_mode_q);
    chk("pull-ups", 1'b1, pullup_en_q);
    {link_unused, pa_e, pb_o} = 3'h7;
    repeat (4) tick;
    chk("port a", 3'h4, {scl_oe_q, scl_out_q, pa_q});
    chk("port b", 3'h3, {sda_oe_q, sda_out_q, pb_q});
    $display("pins done");
    end_sim;
  end
endmodule
`default_nettype wire
